// File: acmp_control.sv
// Comparator input selection, output synchronisation, event flag and register slave
//
// Overview of operation
// - Borrow on and converter off: selected converter channel drives positive input.
// - Borrow off or converter on: dedicated positive pin drives positive input.
// - Channel codes 0 to 10 valid, 3 also current source; others forbidden.
// - Internal-reference bit zero selects negative pin, one selects divider output with source 11, else flags reserved.
// - Divider codes give full, half, quarter, eighth of 2.56 V with source 11.
// - Divider field at bits 5:4 of control B, used only with internal reference.
// - Disable bit powers comparator down, writable anytime, zero powers it up.
// - Raw result reaches status bit through synchroniser, lagging one to two cycles.
// - Event flag sets on the transition kind chosen by the event mode.
// - Interrupt request only when flag, enable and global enable all set.
// - Taking the comparator vector clears the event flag.
// - Writing one to flag clears it; writing zero leaves it.
// - Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Capture-route bit feeds comparator output to timer capture front end.
// - Result is one when positive input exceeds negative input.
`timescale 1ns/100ps
`include "acmp_defines.svh"
module acmp_control
  import acmp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [`ACMP_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [1:0] avsResponse,
  // Analog comparator side
  input wire logic comparatorRaw,
  output logic comparatorPowerDown,
  output logic positiveUseChannel,
  output logic [4:0] positiveChannel,
  output logic currentSourceSelected,
  output logic negativeUseReference,
  output logic [1:0] referenceDivider,
  output logic negativeReserved,
  // Converter side
  input wire logic converterEnable,
  input wire logic [1:0] referenceSourceSelect,
  // CPU interrupt side
  input wire logic globalIrqEnable,
  input wire logic vectorTaken,
  output logic comparatorIrq,
  // Timer capture side
  output logic captureInput,
  output logic captureRouteEnable
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrlB;
    logic compDisable;
    logic intRefSel;
    logic eventFlag;
    logic irqEnable;
    logic captureRoute;
    logic [1:0] eventMode;
    logic [4:0] channelSel;
    logic ackDone;
    logic [31:0] rdata;
    logic waitReq;
    logic [1:0] resp;
    logic powerDown;
    logic useChannel;
    logic [4:0] chanOut;
    logic isrcOut;
    logic useRef;
    logic [1:0] divOut;
    logic negRsvd;
    logic irq;
    logic capIn;
    logic capEn;
  } acmp_ctrl_state_t;

  acmp_ctrl_state_t state_q;
  acmp_ctrl_state_t state_d;

  logic syncOut;
  logic eventHit;
  logic access;
  logic mapped;
  logic wrLow;
  logic [7:0] wb;
  logic [7:0] statusByte;
  logic borrow;
  acmp_neg_t negSel;

  // ----------------------------------------------------------------------------
  // Synchroniser and edge detector
  // ----------------------------------------------------------------------------
  acmp_sync u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rawIn(comparatorRaw),
    .hold(state_q.compDisable),
    .syncOut(syncOut)
  );

  acmp_edge u_edge (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .syncIn(syncOut),
    .eventMode(state_q.eventMode),
    .eventHit(eventHit)
  );

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  always_comb begin
    access = (avsRead | avsWrite) & ~state_q.ackDone;
    mapped = 1'b0;
    if (avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CONTROL_B_IDX)) begin
      mapped = 1'b1;
    end
    if (avsAddress == `ACMP_ADDR_W'(`ACMP_COMPARATOR_CONTROL_STATUS_IDX)) begin
      mapped = 1'b1;
    end
    if (avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CHANNEL_IDX)) begin
      mapped = 1'b1;
    end
    // Write lands on the edge where the master sees waitrequest low
    wrLow = avsWrite & state_q.ackDone & avsByteenable[0];
    wb = avsWritedata[7:0];
    statusByte = {state_q.compDisable, state_q.intRefSel, syncOut, state_q.eventFlag,
                  state_q.irqEnable, state_q.captureRoute, state_q.eventMode};
    borrow = state_q.ctrlB[`ACMP_CCB_MUX_BORROW] & ~converterEnable;
    if (!state_q.intRefSel) begin
      negSel = ACMP_NEG_PIN;
    end else if (referenceSourceSelect == `ACMP_REFSRC_INTERNAL) begin
      negSel = ACMP_NEG_REF;
    end else begin
      negSel = ACMP_NEG_RSVD;
    end
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // Bus handshake: one wait cycle, then answer, then re-arm
    state_d.ackDone = 1'b0;
    state_d.waitReq = 1'b1;
    if (access) begin
      state_d.ackDone = 1'b1;
      state_d.waitReq = 1'b0;
      state_d.resp = mapped ? 2'b00 : 2'b10;
      state_d.rdata = 32'h0000_0000;
      if (avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CONTROL_B_IDX)) begin
        state_d.rdata[7:0] = state_q.ctrlB;
      end
      if (avsAddress == `ACMP_ADDR_W'(`ACMP_COMPARATOR_CONTROL_STATUS_IDX)) begin
        state_d.rdata[7:0] = statusByte;
      end
      if (avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CHANNEL_IDX)) begin
        state_d.rdata[4:0] = state_q.channelSel;
      end
    end
    // Register writes
    if (wrLow && avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CONTROL_B_IDX)) begin
      state_d.ctrlB = wb & `ACMP_CCB_WMASK;
    end
    if (wrLow && avsAddress == `ACMP_ADDR_W'(`ACMP_CONVERTER_CHANNEL_IDX)) begin
      state_d.channelSel = wb[4:0];
    end
    if (wrLow && avsAddress == `ACMP_ADDR_W'(`ACMP_COMPARATOR_CONTROL_STATUS_IDX)) begin
      state_d.compDisable = wb[`ACMP_CCS_DISABLE];
      state_d.intRefSel = wb[`ACMP_CCS_INTREF];
      state_d.irqEnable = wb[`ACMP_CCS_IRQ_EN];
      state_d.captureRoute = wb[`ACMP_CCS_CAPTURE];
      state_d.eventMode = wb[`ACMP_CCS_MODE_HI:`ACMP_CCS_MODE_LO];
      if (wb[`ACMP_CCS_FLAG]) begin
        state_d.eventFlag = 1'b0;
      end
    end
    if (vectorTaken) begin
      state_d.eventFlag = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (eventHit) begin
      state_d.eventFlag = 1'b1;
    end
    // Registered outputs
    state_d.powerDown = state_d.compDisable;
    state_d.useChannel = borrow;
    state_d.chanOut = borrow ? state_q.channelSel : 5'h00;
    state_d.isrcOut = borrow && state_q.channelSel == `ACMP_CHAN_CURRENT_SOURCE_NODE;
    state_d.useRef = negSel == ACMP_NEG_REF;
    state_d.divOut = state_q.ctrlB[`ACMP_CCB_REFDIV_HI:`ACMP_CCB_REFDIV_LO];
    state_d.negRsvd = negSel == ACMP_NEG_RSVD;
    state_d.irq = state_d.eventFlag & state_d.irqEnable & globalIrqEnable;
    state_d.capEn = state_d.captureRoute;
    state_d.capIn = state_d.captureRoute & syncOut;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.waitReq <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign avsReaddata = state_q.rdata;
  assign avsWaitrequest = state_q.waitReq;
  assign avsResponse = state_q.resp;
  assign comparatorPowerDown = state_q.powerDown;
  assign positiveUseChannel = state_q.useChannel;
  assign positiveChannel = state_q.chanOut;
  assign currentSourceSelected = state_q.isrcOut;
  assign negativeUseReference = state_q.useRef;
  assign referenceDivider = state_q.divOut;
  assign negativeReserved = state_q.negRsvd;
  assign comparatorIrq = state_q.irq;
  assign captureInput = state_q.capIn;
  assign captureRouteEnable = state_q.capEn;

endmodule

// File: acmp_control_assertions.sv
// Port-level checker for the comparator control block
`timescale 1ns/100ps
module acmp_control_assertions
  import acmp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  input wire logic [1:0] avsResponse,
  input wire logic converterEnable,
  input wire logic [1:0] referenceSourceSelect,
  input wire logic globalIrqEnable,
  input wire logic positiveUseChannel,
  input wire logic [4:0] positiveChannel,
  input wire logic currentSourceSelected,
  input wire logic negativeUseReference,
  input wire logic negativeReserved,
  input wire logic comparatorIrq,
  input wire logic comparatorPowerDown,
  input wire logic captureInput,
  input wire logic captureRouteEnable
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_POS_CHAN: assert property (positiveUseChannel |-> !$past(converterEnable))
    else $error("channel borrowed while converter on");
  AST_POS_PIN: assert property (!positiveUseChannel |-> positiveChannel == 5'h00)
    else $error("channel shown while pin selected");
  AST_CURRENT_SOURCE_NODE: assert property (currentSourceSelected == (positiveUseChannel
    && positiveChannel == 5'h03))
    else $error("current source node mismatch");
  AST_NEG_REF: assert property (negativeUseReference |->
    $past(referenceSourceSelect) == 2'h3 && !negativeReserved)
    else $error("reference used with wrong source");
  AST_NEG_RSVD: assert property (negativeReserved |-> $past(referenceSourceSelect) != 2'h3)
    else $error("reserved flagged with valid source");
  AST_IRQ_GIE: assert property (comparatorIrq |-> $past(globalIrqEnable))
    else $error("irq without global enable");
  AST_CAPTURE: assert property (captureInput |-> captureRouteEnable)
    else $error("capture fed while route off");
  // Three samples so the sync stage has surely frozen
  AST_FREEZE: assert property ((comparatorPowerDown && captureRouteEnable)[*3]
    |-> $stable(captureInput))
    else $error("output moved while disabled");
  AST_ANSWER: assert property (($rose(avsRead) || $rose(avsWrite)) |-> ##[1:3] !avsWaitrequest)
    else $error("bus answer late");
  AST_WAIT_PULSE: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low too long");
endmodule

bind acmp_control acmp_control_assertions u_acmp_control_assertions (.core_clk, .reset_n,
  .avsRead, .avsWrite, .avsWaitrequest, .avsResponse, .converterEnable, .referenceSourceSelect,
  .globalIrqEnable, .positiveUseChannel, .positiveChannel, .currentSourceSelected,
  .negativeUseReference, .negativeReserved, .comparatorIrq, .comparatorPowerDown,
  .captureInput, .captureRouteEnable);

// File: acmp_control_bench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
`include "acmp_defines.svh"
module acmp_control_bench
  import acmp_pkg::*;
;
  logic core_clk, reset_n, avsRead, avsWrite, avsWaitrequest, comparatorRaw;
  logic [9:0] avsAddress;
  logic [3:0] avsByteenable;
  logic [31:0] avsWritedata, avsReaddata;
  logic [1:0] avsResponse, referenceDivider, referenceSourceSelect, rsv;
  logic comparatorPowerDown, positiveUseChannel, currentSourceSelected, negativeUseReference;
  logic negativeReserved, converterEnable, globalIrqEnable, vectorTaken, comparatorIrq;
  logic captureInput, captureRouteEnable;
  logic [4:0] positiveChannel;
  logic [7:0] rdv;
  logic e;
  int errorCnt, checksDone, cyc;

  acmp_control u_acmp_control (.core_clk, .reset_n, .avsAddress, .avsRead, .avsWrite,
    .avsByteenable, .avsWritedata, .avsReaddata, .avsWaitrequest, .avsResponse,
    .comparatorRaw, .comparatorPowerDown, .positiveUseChannel, .positiveChannel,
    .currentSourceSelected, .negativeUseReference, .referenceDivider, .negativeReserved,
    .converterEnable, .referenceSourceSelect, .globalIrqEnable, .vectorTaken,
    .comparatorIrq, .captureInput, .captureRouteEnable);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic completeRun;
    if (errorCnt == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] s, input logic [7:0] x);
    checksDone++;
    if (s !== x) begin
      errorCnt++;
      $display("MISMATCH %0t got %h exp %h", $time, s, x);
    end
  endtask

  // Answer taken at the rising edge, before that edge updates it
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= {24'h00_0000, d};
    @(posedge core_clk);
    while (avsWaitrequest !== 1'b0) @(posedge core_clk);
    rdv = avsReaddata[7:0];
    rsv = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic ws(input logic [7:0] d);
    bus(1'b1, `ACMP_COMPARATOR_CONTROL_STATUS_IDX, d);
  endtask

  task automatic cs(input logic [7:0] x);
    bus(1'b0, `ACMP_COMPARATOR_CONTROL_STATUS_IDX, 8'h00);
    check(rdv, x);
  endtask

  task automatic st;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ----------------------------------------
  // Clock, reset, timeout
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      completeRun();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {reset_n, avsRead, avsWrite, comparatorRaw, converterEnable, vectorTaken} = 6'h00;
    {avsAddress, avsWritedata, globalIrqEnable} = '0;
    avsByteenable = 4'h1;
    referenceSourceSelect = 2'h3;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    cs(8'h00);
    bus(1'b0, `ACMP_CONVERTER_CONTROL_B_IDX, 8'h00);
    check(rdv, 8'h00);
    bus(1'b0, 10'h3FF, 8'h00);
    check({rdv[5:0], rsv}, 8'h02);
    bus(1'b1, `ACMP_CONVERTER_CONTROL_B_IDX, 8'hFF);
    bus(1'b0, `ACMP_CONVERTER_CONTROL_B_IDX, 8'h00);
    check(rdv, 8'hF7);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `ACMP_CONVERTER_CONTROL_B_IDX, {2'b01, 2'(i), 4'h0});
      st();
      check(8'(referenceDivider), 8'(i));
    end
    ws(8'h40);
    st();
    check({negativeUseReference, negativeReserved}, 8'h02);
    @(posedge core_clk);
    referenceSourceSelect <= 2'h1;
    st();
    check({negativeUseReference, negativeReserved}, 8'h01);
    ws(8'h00);
    st();
    check({negativeUseReference, negativeReserved}, 8'h00);
    for (int c = 0; c < 11; c++) begin
      bus(1'b1, `ACMP_CONVERTER_CHANNEL_IDX, 8'(c));
      st();
      check({positiveUseChannel, positiveChannel}, 8'(c) | 8'h20);
      check(8'(currentSourceSelected), 8'(c == 3));
    end
    @(posedge core_clk);
    converterEnable <= 1'b1;
    st();
    check({positiveUseChannel, positiveChannel}, 8'h00);
    @(posedge core_clk);
    globalIrqEnable <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      ws({6'b000100, 2'(m)});
      ws({6'b000110, 2'(m)});
      @(posedge core_clk);
      comparatorRaw <= 1'b1;
      st();
      e = (m == 0 || m == 3);
      check(8'(comparatorIrq), 8'(e));
      cs({3'b001, e, 2'b10, 2'(m)});
      ws({6'b000110, 2'(m)});
      @(posedge core_clk);
      comparatorRaw <= 1'b0;
      st();
      e = (m == 0 || m == 2);
      cs({3'b000, e, 2'b10, 2'(m)});
      ws({6'b000100, 2'(m)});
    end
    ws(8'h10);
    ws(8'h18);
    globalIrqEnable <= 1'b0;
    comparatorRaw <= 1'b1;
    st();
    check(8'(comparatorIrq), 8'h00);
    ws(8'h08);
    cs(8'h38);
    @(posedge core_clk);
    globalIrqEnable <= 1'b1;
    st();
    check(8'(comparatorIrq), 8'h01);
    check(8'(captureInput), 8'h00);
    @(posedge core_clk);
    vectorTaken <= 1'b1;
    @(posedge core_clk);
    vectorTaken <= 1'b0;
    st();
    cs(8'h28);
    ws(8'h00);
    ws(8'h84);
    st();
    check({comparatorPowerDown, captureRouteEnable, captureInput}, 8'h07);
    @(posedge core_clk);
    comparatorRaw <= 1'b0;
    st();
    cs(8'hA4);
    ws(8'h04);
    st();
    check({comparatorPowerDown, captureInput}, 8'h00);
    cs(8'h14);
    completeRun();
  end
endmodule

// File: acmp_defines.svh
// Register offsets, field positions, reset values and timing counts for the comparator control
`ifndef ACMP_DEFINES_SVH
`define ACMP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ACMP_CONVERTER_CONTROL_B_IDX 8'h7B
`define ACMP_COMPARATOR_CONTROL_STATUS_IDX 8'h50
`define ACMP_CONVERTER_CHANNEL_IDX 8'h7C
`define ACMP_CONVERTER_CONTROL_A_IDX 8'h7A
`define ACMP_ADDR_W 10

// ----------------------------------------------------------------------------
// Converter control B fields
// ----------------------------------------------------------------------------
`define ACMP_CCB_BIPOLAR 7
`define ACMP_CCB_MUX_BORROW 6
`define ACMP_CCB_REFDIV_HI 5
`define ACMP_CCB_REFDIV_LO 4
`define ACMP_CCB_WMASK 8'hF7
`define ACMP_CCB_RESET 8'h00

// ----------------------------------------------------------------------------
// Comparator control/status fields
// ----------------------------------------------------------------------------
`define ACMP_CCS_DISABLE 7
`define ACMP_CCS_INTREF 6
`define ACMP_CCS_OUTPUT 5
`define ACMP_CCS_FLAG 4
`define ACMP_CCS_IRQ_EN 3
`define ACMP_CCS_CAPTURE 2
`define ACMP_CCS_MODE_HI 1
`define ACMP_CCS_MODE_LO 0
`define ACMP_CCS_RESET 8'h00

// ----------------------------------------------------------------------------
// Channel and reference encodings
// ----------------------------------------------------------------------------
`define ACMP_CHAN_MAX 5'h0A
`define ACMP_CHAN_CURRENT_SOURCE_NODE 5'h03
`define ACMP_REFSRC_INTERNAL 2'h3
`define ACMP_READ_WAIT 1

`endif

// File: acmp_edge.sv
// Event detector on the synchronised comparator output
`timescale 1ns/100ps
module acmp_edge
  import acmp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic syncIn,
  input wire logic [1:0] eventMode,
  output logic eventHit
);

  typedef struct packed {
    logic prev;
  } acmp_edge_state_t;

  acmp_edge_state_t state_q;
  acmp_edge_state_t state_d;
  acmp_mode_t mode;

  // ----------------------------------------------------------------------------
  // Edge compare
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.prev = syncIn;
    mode = acmp_mode_t'(eventMode);
    eventHit = 1'b0;
    unique case (mode)
      ACMP_MODE_TOGGLE: eventHit = syncIn ^ state_q.prev;
      ACMP_MODE_RSVD: eventHit = 1'b0;
      ACMP_MODE_FALL: eventHit = state_q.prev & ~syncIn;
      ACMP_MODE_RISE: eventHit = syncIn & ~state_q.prev;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// File: acmp_pkg.sv
// Types shared by the comparator control block
package acmp_pkg;

  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE = 2'b00,
    ACMP_MODE_RSVD = 2'b01,
    ACMP_MODE_FALL = 2'b10,
    ACMP_MODE_RISE = 2'b11
  } acmp_mode_t;

  typedef enum logic [1:0] {
    ACMP_NEG_PIN = 2'b00,
    ACMP_NEG_REF = 2'b01,
    ACMP_NEG_RSVD = 2'b10
  } acmp_neg_t;

endpackage

// File: acmp_sync.sv
// Two-stage synchroniser with hold for the raw comparator result
`timescale 1ns/100ps
module acmp_sync
  import acmp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rawIn,
  input wire logic hold,
  output logic syncOut
);

  typedef struct packed {
    logic meta;
    logic sync;
  } acmp_sync_state_t;

  acmp_sync_state_t state_q;
  acmp_sync_state_t state_d;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.meta = rawIn;
    // Powered-down comparator output is junk, so freeze the last clean value
    if (!hold) begin
      state_d.sync = state_q.meta;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.sync;

endmodule
